// ===== core/ulr_regs.svh
// register offsets, bit positions, reset values and thresholds of the uart receive/status block
// assumes inclusion by bare name from the core module and the testbench
`ifndef ULR_REGS_SVH
`define ULR_REGS_SVH

`define ULR_ADDR_W          12
`define ULR_OFS_HOLDING     12'hF40
`define ULR_OFS_STATUS      12'hF41
`define ULR_OFS_CTRL        12'hF50
`define ULR_OFS_IRQ_STS     12'hF51
`define ULR_OFS_IRQ_MASK    12'hF52

`define ULR_ST_RDA          7
`define ULR_ST_ERR6         6
`define ULR_ST_OVR          5
`define ULR_ST_FRM          4
`define ULR_ST_BRK          3
`define ULR_ST_TX_HOLDING_EMPTY         2
`define ULR_ST_TXE          1
`define ULR_ST_BIT0         0

`define ULR_CTRL_LIN        0
`define ULR_CTRL_SLAVE      1
`define ULR_CTRL_LOOP       2
`define ULR_CTRL_GATE       3
`define ULR_CTRL_RESET      8'h00

`define ULR_IRQ_RX          0
`define ULR_IRQ_ERR6        1
`define ULR_IRQ_OVR         2
`define ULR_IRQ_FRM         3
`define ULR_IRQ_BRK         4
`define ULR_IRQ_ATB         5
`define ULR_IRQ_W           6
`define ULR_IRQ_MASK_RESET  6'h00

`define ULR_BRK_SLEEP_BITS  8'h04
`define ULR_BRK_WAIT_BITS   8'h0B
`define ULR_BRK_ACT_BITS    8'h0A

`endif

// ===== core/ulr_pkg.sv
// types shared by the uart receive/status block and its neighbours
// assumes the receiver, transmitter and lin state machine live outside
package ulr_pkg;

    // one finished character from the receiver
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       parity_bit;
        logic       stop_ok;
        logic       parity_err;
    } ulr_rx_char_t;

    // lin protocol events, each flag a one-cycle pulse, with the low-bit count
    typedef struct packed {
        logic       echo_mismatch;
        logic       autobaud_done;
        logic       autobaud_overflow;
        logic       low_end;
        logic [7:0] low_bits;
    } ulr_lin_evt_t;

    typedef enum logic [1:0] {
        LIN_SLEEP,
        LIN_WAIT_BREAK,
        LIN_ACTIVE,
        LIN_OTHER
    } ulr_lin_state_t;

endpackage

// ===== core/ulr_core.sv
// receive holding register, line status register, control and interrupt registers of a uart/lin port
// assumes receiver, transmitter and lin state machine on the same clock; cts pin is asynchronous
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "ulr_regs.svh"

// Functional notes
// [R1] received byte held read-only at holding address; writes there feed the transmitter
// [R2] one status register, layout chosen by uart or lin mode
// [R3] bit 7 set while byte waits; cleared by holding read
// [R4] standard mode bit 6 parity fault; cleared by holding read
// [R5] bit 5 overrun when byte arrives unread; cleared by holding read
// [R6] bit 4 framing fault when stop bit missing; cleared by holding read
// [R7] standard mode bit 3 break when data, parity and stop all zero
// [R8] bit 2 high while transmit holding empty; cleared by holding write
// [R9] bit 1 reports transmit shifter idle
// [R10] standard bit 0 is cts level, or byte-waiting when loopback selected
// [R11] cts gates transmission only when send gate enable is one
// [R12] lin bit 6 echo mismatch; cleared by status or holding read
// [R13] lin slave bit 0 autobaud done, cleared by status read, zero in master
// [R14] lin slave autobaud overflow sets overrun and autobaud done together
// [R15] lin break after 4, 11 or 10 low bits by state; cleared by either read
module ulr_core
    import ulr_pkg::*;
(
    input  wire logic                    clock_i,
    input  wire logic                    rst_i,
    input  wire logic                    ce_i,
    input  wire logic [`ULR_ADDR_W-1:0]  addr_i,
    input  wire logic [7:0]              wr_data_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [7:0]              rd_data_o,
    output logic                         irq_o,
    input  wire ulr_rx_char_t            rx_char_i,
    input  wire ulr_lin_evt_t            lin_evt_i,
    input  wire ulr_lin_state_t          lin_state_i,
    input  wire logic                    tx_take_i,
    input  wire logic                    tx_shifter_idle_i,
    input  wire logic                    cts_n_i,
    output logic      [7:0]              tx_data_o,
    output logic                         tx_load_o,
    output logic                         tx_send_ok_o
);

    ////////////////////////////////////////////////////////////////////////////
    // decode

    logic       hold_rd;
    logic       hold_wr;
    logic       stat_rd;
    logic       ctrl_wr;
    logic       isr_wr;
    logic       imr_wr;

    assign hold_rd = ce_i && rd_i && (addr_i == `ULR_OFS_HOLDING);
    assign hold_wr = ce_i && wr_i && (addr_i == `ULR_OFS_HOLDING);
    assign stat_rd = ce_i && rd_i && (addr_i == `ULR_OFS_STATUS);
    assign ctrl_wr = ce_i && wr_i && (addr_i == `ULR_OFS_CTRL);
    assign isr_wr  = ce_i && wr_i && (addr_i == `ULR_OFS_IRQ_STS);
    assign imr_wr  = ce_i && wr_i && (addr_i == `ULR_OFS_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // control register

    logic [7:0] ctrl;
    logic       lin_mode;
    logic       lin_slave;
    logic       loopback_select;
    logic       send_gate_enable;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl <= `ULR_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl <= {4'h0, wr_data_i[3:0]};
        end
    end

    assign lin_mode         = ctrl[`ULR_CTRL_LIN];
    assign lin_slave        = ctrl[`ULR_CTRL_SLAVE];
    assign loopback_select  = ctrl[`ULR_CTRL_LOOP];
    assign send_gate_enable = ctrl[`ULR_CTRL_GATE];

    ////////////////////////////////////////////////////////////////////////////
    // event detection

    logic       rx_new;
    logic       rx_byte_waiting;
    logic       rx_overrun;
    logic       framing_evt;
    logic       std_break;
    logic       lin_break;
    logic [7:0] brk_limit;
    logic       atb_evt;
    logic       ovr_evt;
    logic       brk_evt;
    logic       err6_evt;

    assign rx_new     = ce_i && rx_char_i.valid;
    assign rx_overrun = rx_new && rx_byte_waiting && !hold_rd;
    assign std_break  = (rx_char_i.data == 8'h00) && !rx_char_i.parity_bit && !rx_char_i.stop_ok;
    assign framing_evt = rx_new && !rx_char_i.stop_ok;

    always_comb begin
        case (lin_state_i)
            LIN_SLEEP:      brk_limit = `ULR_BRK_SLEEP_BITS;
            LIN_WAIT_BREAK: brk_limit = `ULR_BRK_WAIT_BITS;
            LIN_ACTIVE:     brk_limit = `ULR_BRK_ACT_BITS;
            default:        brk_limit = 8'hFF;
        endcase
    end

    assign lin_break = ce_i && lin_mode && lin_evt_i.low_end && (lin_state_i != LIN_OTHER)
                       && (lin_evt_i.low_bits >= brk_limit); // R15
    assign atb_evt   = ce_i && lin_mode && lin_slave
                       && (lin_evt_i.autobaud_done || lin_evt_i.autobaud_overflow); // R13 R14
    assign ovr_evt   = rx_overrun || (ce_i && lin_mode && lin_slave && lin_evt_i.autobaud_overflow); // R5 R14
    assign brk_evt   = (rx_new && !lin_mode && std_break) || lin_break;
    assign err6_evt  = lin_mode ? (ce_i && lin_evt_i.echo_mismatch)
                                : (rx_new && rx_char_i.parity_err);

    ////////////////////////////////////////////////////////////////////////////
    // receive holding and status flags

    logic [7:0] receive_holding;
    logic       parity_fault;
    logic       bus_echo_mismatch;
    logic       overrun_fault;
    logic       framing_fault;
    logic       line_break_seen;
    logic       autobaud_done;
    logic       tx_holding_empty;

    // an overrun leaves the unread byte in place
    always_ff @(posedge clock_i) begin
        if (rst_i) receive_holding <= 8'h00;
        else if (rx_new && (!rx_byte_waiting || hold_rd)) receive_holding <= rx_char_i.data; // R1
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) rx_byte_waiting <= 1'b0;
        else if (rx_new) rx_byte_waiting <= 1'b1; // R3
        else if (hold_rd) rx_byte_waiting <= 1'b0; // R3
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) parity_fault <= 1'b0;
        else if (rx_new && !lin_mode && rx_char_i.parity_err) parity_fault <= 1'b1; // R4
        else if (hold_rd) parity_fault <= 1'b0; // R4
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) bus_echo_mismatch <= 1'b0;
        else if (ce_i && lin_mode && lin_evt_i.echo_mismatch) bus_echo_mismatch <= 1'b1; // R12
        else if (hold_rd || stat_rd) bus_echo_mismatch <= 1'b0; // R12
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) overrun_fault <= 1'b0;
        else if (ovr_evt) overrun_fault <= 1'b1; // R5 R14
        else if (hold_rd) overrun_fault <= 1'b0; // R5 R14
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) framing_fault <= 1'b0;
        else if (framing_evt) framing_fault <= 1'b1; // R6
        else if (hold_rd) framing_fault <= 1'b0; // R6
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) line_break_seen <= 1'b0;
        else if (brk_evt) line_break_seen <= 1'b1; // R7 R15
        else if (hold_rd || (stat_rd && lin_mode)) line_break_seen <= 1'b0; // R7 R15
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) autobaud_done <= 1'b0;
        else if (atb_evt) autobaud_done <= 1'b1; // R13
        else if (stat_rd) autobaud_done <= 1'b0; // R13
    end

    // a holding write in the take cycle is a new byte, so it wins
    always_ff @(posedge clock_i) begin
        if (rst_i) tx_holding_empty <= 1'b1;
        else if (hold_wr) tx_holding_empty <= 1'b0; // R8
        else if (ce_i && tx_take_i) tx_holding_empty <= 1'b1; // R8
    end

    ////////////////////////////////////////////////////////////////////////////
    // clear-to-send path

    logic cts_meta;
    logic cts_sync;
    logic cts_src;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cts_meta <= 1'b1;
            cts_sync <= 1'b1;
        end else if (ce_i) begin
            cts_meta <= cts_n_i;
            cts_sync <= cts_meta;
        end
    end

    assign cts_src = loopback_select ? rx_byte_waiting : cts_sync; // R10

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            tx_send_ok_o <= 1'b1;
        end else if (ce_i) begin
            tx_send_ok_o <= !send_gate_enable || !cts_src; // R11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit holding hand-off

    always_ff @(posedge clock_i) begin
        if (rst_i) tx_data_o <= 8'h00;
        else if (hold_wr) tx_data_o <= wr_data_i; // R1
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) tx_load_o <= 1'b0;
        else if (ce_i) tx_load_o <= hold_wr;
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask

    logic [`ULR_IRQ_W-1:0] irq_sts;
    logic [`ULR_IRQ_W-1:0] irq_mask;
    logic [`ULR_IRQ_W-1:0] irq_set;

    assign irq_set = {atb_evt, brk_evt, framing_evt, ovr_evt, err6_evt, rx_new};

    // set wins over write-one-to-clear
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_sts <= '0;
        end else if (ce_i) begin
            irq_sts <= irq_set | (irq_sts & ~(isr_wr ? wr_data_i[`ULR_IRQ_W-1:0] : '0));
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_mask <= `ULR_IRQ_MASK_RESET;
        end else if (imr_wr) begin
            irq_mask <= wr_data_i[`ULR_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |(irq_sts & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data

    logic [7:0] status_view;
    logic [7:0] rd_next;

    always_comb begin
        status_view                = 8'h00;
        status_view[`ULR_ST_RDA]   = rx_byte_waiting;
        status_view[`ULR_ST_ERR6]  = lin_mode ? bus_echo_mismatch : parity_fault; // R2
        status_view[`ULR_ST_OVR]   = overrun_fault;
        status_view[`ULR_ST_FRM]   = framing_fault;
        status_view[`ULR_ST_BRK]   = line_break_seen;
        status_view[`ULR_ST_TX_HOLDING_EMPTY]  = tx_holding_empty;
        status_view[`ULR_ST_TXE]   = tx_shifter_idle_i; // R9
        status_view[`ULR_ST_BIT0]  = lin_mode ? (lin_slave && autobaud_done) : cts_src; // R2 R10 R13
    end

    always_comb begin
        case (addr_i)
            `ULR_OFS_HOLDING:  rd_next = receive_holding; // R1
            `ULR_OFS_STATUS:   rd_next = status_view;
            `ULR_OFS_CTRL:     rd_next = ctrl;
            `ULR_OFS_IRQ_STS:  rd_next = {2'b00, irq_sts};
            `ULR_OFS_IRQ_MASK: rd_next = {2'b00, irq_mask};
            default:           rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rd_data_o <= 8'h00;
        end else if (ce_i) begin
            rd_data_o <= rd_i ? rd_next : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_byte_in;
        rx_new && !rx_byte_waiting;
    endsequence
    sequence s_hold_read_quiet;
        hold_rd && !rx_new && !ovr_evt;
    endsequence

    property p_rx_holds_data;
        s_byte_in |=> receive_holding == $past(rx_char_i.data);
    endproperty
    a_rx_holds_data: assert property (p_rx_holds_data) else $error("holding byte not captured"); // R1
    property p_read_returns_byte;
        hold_rd |=> rd_data_o == $past(receive_holding);
    endproperty
    a_read_returns_byte: assert property (p_read_returns_byte) else $error("holding read data wrong"); // R1
    property p_rda_cycle;
        s_byte_in ##1 (!rx_new && !hold_rd) |-> rx_byte_waiting;
    endproperty
    a_rda_cycle: assert property (p_rda_cycle) else $error("byte waiting not set"); // R3
    property p_read_clears;
        s_hold_read_quiet |=> !rx_byte_waiting && !overrun_fault && !framing_fault && !parity_fault;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("holding read left flags set"); // R3
    property p_overrun_keeps;
        rx_overrun |=> overrun_fault && $stable(receive_holding);
    endproperty
    a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun mishandled"); // R5
    // back-to-back holding writes are legal, so only the cycle after the write is checked
    property p_tx_holding_empty_write;
        hold_wr |=> !tx_holding_empty && tx_load_o && (tx_data_o == $past(wr_data_i));
    endproperty
    a_tx_holding_empty_write: assert property (p_tx_holding_empty_write) else $error("holding empty not cleared"); // R8
    property p_send_gate;
        ce_i && !send_gate_enable |=> tx_send_ok_o;
    endproperty
    a_send_gate: assert property (p_send_gate) else $error("send blocked with gate off"); // R11
    property p_atb_master;
        stat_rd && lin_mode && !lin_slave |=> rd_data_o[`ULR_ST_BIT0] == 1'b0;
    endproperty
    a_atb_master: assert property (p_atb_master) else $error("autobaud bit set in master"); // R13
    property p_autobaud_ovr;
        atb_evt && lin_evt_i.autobaud_overflow |=> overrun_fault && autobaud_done;
    endproperty
    a_autobaud_ovr: assert property (p_autobaud_ovr) else $error("autobaud overflow flags missing"); // R14
    property p_lin_break;
        ce_i && lin_mode && lin_evt_i.low_end && lin_state_i == LIN_SLEEP
            && lin_evt_i.low_bits < `ULR_BRK_SLEEP_BITS && !line_break_seen |=> !line_break_seen;
    endproperty
    a_lin_break: assert property (p_lin_break) else $error("short low taken as break"); // R15
    property p_echo_clear;
        stat_rd && lin_mode && !lin_evt_i.echo_mismatch |=> !bus_echo_mismatch;
    endproperty
    a_echo_clear: assert property (p_echo_clear) else $error("echo mismatch not cleared"); // R12

endmodule

// ===== tb/ulr_peer.sv
// remote serial node model: delivers received characters and lin events, drains the transmit holding byte
// assumes the core's clock and reset; the testbench calls its tasks and drives cts and lin state itself
`timescale 1ns/1ps
module ulr_peer
    import ulr_pkg::*;
#(
    parameter int TX_CYCLES = 24
)(
    input  wire logic     clock_i,
    input  wire logic     rst_i,
    input  wire logic     tx_load_i,
    input  wire logic     tx_send_ok_i,
    output ulr_rx_char_t  rx_char_o,
    output ulr_lin_evt_t  lin_evt_o,
    output logic          tx_take_o,
    output logic          tx_shifter_idle_o
);
    logic pending = 1'b0;
    int   busy    = 0;

    initial begin
        rx_char_o = '0;
        lin_evt_o = '0;
        tx_take_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter: takes the holding byte only while sending is allowed
    always @(posedge clock_i) begin
        tx_take_o <= 1'b0;
        if (rst_i) begin
            pending <= 1'b0;
            busy    <= 0;
        end else if (tx_load_i) begin
            pending <= 1'b1;
        end else if (pending && tx_send_ok_i && busy == 0) begin
            pending   <= 1'b0;
            tx_take_o <= 1'b1;
            busy      <= TX_CYCLES;
        end else if (busy != 0) begin
            busy <= busy - 1;
        end
    end
    assign tx_shifter_idle_o = (busy == 0);

    ////////////////////////////////////////////////////////////////////////
    // receive side: one-cycle pulses, fields scrambled afterwards
    task automatic send_char(input logic [7:0] d, input logic par, input logic stop, input logic perr);
        @(posedge clock_i);
        rx_char_o <= '{1'b1, d, par, stop, perr};
        @(posedge clock_i);
        rx_char_o <= '{1'b0, ~d, ~par, ~stop, ~perr};
    endtask

    task automatic lin_pulse(input ulr_lin_evt_t e);
        @(posedge clock_i);
        lin_evt_o <= e;
        @(posedge clock_i);
        lin_evt_o <= '{1'b0, 1'b0, 1'b0, 1'b0, ~e.low_bits};
    endtask
endmodule

// ===== tb/tb_ulr_core.sv
// self-checking bench of the receive holding and line status registers
// assumes ulr_core, ulr_pkg, ulr_regs.svh and the ulr_peer model
`timescale 1ns/1ps
`include "ulr_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_ulr_core
    import ulr_pkg::*;
;
    localparam logic [11:0] HOLD = `ULR_OFS_HOLDING;
    localparam logic [11:0] STAT = `ULR_OFS_STATUS;
    localparam logic [11:0] CTRL = `ULR_OFS_CTRL;
    localparam logic [11:0] ISTS = `ULR_OFS_IRQ_STS;
    localparam logic [11:0] IMSK = `ULR_OFS_IRQ_MASK;
    logic           clock_i      = 1'b0;
    logic           rst_i        = 1'b1;
    logic           ce_i         = 1'b1;
    logic           wr_i         = 1'b0;
    logic           rd_i         = 1'b0;
    logic           cts_n_i      = 1'b1;
    logic [11:0]    addr_i       = '0;
    logic [7:0]     wr_data_i    = '0;
    ulr_lin_state_t lin_state_i  = LIN_OTHER;
    logic [7:0]     rd_data_o;
    logic [7:0]     tx_data_o;
    logic           irq_o;
    logic           tx_load_o;
    logic           tx_send_ok_o;
    logic           tx_take;
    logic           tx_idle;
    ulr_rx_char_t   rx_char;
    ulr_lin_evt_t   lin_evt;
    int             fail_count   = 0;
    int             n_compared   = 0;
    ulr_lin_state_t st [3]       = '{LIN_SLEEP, LIN_WAIT_BREAK, LIN_ACTIVE};
    logic [7:0]     thr [3]      = '{8'h04, 8'h0B, 8'h0A};
    logic [7:0]     d;

    initial begin
        forever #2.5 clock_i = ~clock_i;
    end

    ulr_core ulr_core_inst (
        .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o), .rx_char_i(rx_char),
        .lin_evt_i(lin_evt), .lin_state_i(lin_state_i), .tx_take_i(tx_take), .tx_shifter_idle_i(tx_idle),
        .cts_n_i(cts_n_i), .tx_data_o(tx_data_o), .tx_load_o(tx_load_o), .tx_send_ok_o(tx_send_ok_o)
    );

    ulr_peer ulr_peer_inst (
        .clock_i(clock_i), .rst_i(rst_i), .tx_load_i(tx_load_o), .tx_send_ok_i(tx_send_ok_o),
        .rx_char_o(rx_char), .lin_evt_o(lin_evt), .tx_take_o(tx_take), .tx_shifter_idle_o(tx_idle)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clock_i);
        addr_i    <= a;
        wr_data_i <= v;
        wr_i      <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        v = rd_data_o;
    endtask

    task automatic chk(input string nm, input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        `CHK(nm, e, v & m)
    endtask

    task automatic wait_idle(input logic v);
        int k;
        k = 0;
        while (tx_idle !== v && k < 200) begin
            @(posedge clock_i);
            k++;
        end
        if (k == 200) begin
            fail_count++;
            $display("mismatch shifter_idle expected %b seen %b", v, tx_idle);
            results();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        chk("status_reset", STAT, 8'hFF, 8'h07);
        chk("ctrl_reset", CTRL, 8'hFF, 8'h00);
        chk("mask_reset", IMSK, 8'hFF, 8'h00);
        chk("alias_unmapped", 12'hF48, 8'hFF, 8'h00);
        $display("test reset done");
        ulr_peer_inst.send_char(8'h5A, 1'b0, 1'b1, 1'b0);
        chk("status_rx", STAT, 8'hFF, 8'h87);
        chk("holding", HOLD, 8'hFF, 8'h5A);
        chk("status_read", STAT, 8'hFF, 8'h07);
        ulr_peer_inst.send_char(8'h3C, 1'b1, 1'b0, 1'b1);
        chk("status_err", STAT, 8'hFF, 8'hD7);
        chk("holding_err", HOLD, 8'hFF, 8'h3C);
        chk("status_err_clr", STAT, 8'hFF, 8'h07);
        ulr_peer_inst.send_char(8'h00, 1'b0, 1'b0, 1'b0);
        chk("status_brk", STAT, 8'hFF, 8'h9F);
        chk("holding_brk", HOLD, 8'hFF, 8'h00);
        chk("status_brk_clr", STAT, 8'hFF, 8'h07);
        ulr_peer_inst.send_char(8'h11, 1'b0, 1'b1, 1'b0);
        ulr_peer_inst.send_char(8'h22, 1'b0, 1'b1, 1'b0);
        chk("status_ovr", STAT, 8'hFF, 8'hA7);
        chk("holding_ovr", HOLD, 8'hFF, 8'h11);
        chk("status_ovr_clr", STAT, 8'hFF, 8'h07);
        $display("test receive done");
        wr(HOLD, 8'hA5);
        #1;
        `CHK("tx_load", 1'b1, tx_load_o)
        chk("tx_holding_empty_low", STAT, 8'h04, 8'h00);
        `CHK("tx_data", 8'hA5, tx_data_o)
        wait_idle(1'b0);
        chk("shifting", STAT, 8'h06, 8'h04);
        wait_idle(1'b1);
        chk("tx_done", STAT, 8'hFF, 8'h07);
        wr(CTRL, 8'h08);
        repeat (2) @(posedge clock_i);
        `CHK("send_ok_gated", 1'b0, tx_send_ok_o)
        wr(HOLD, 8'h66);
        repeat (20) @(posedge clock_i);
        chk("tx_holding_empty_held", STAT, 8'h04, 8'h00);
        @(posedge clock_i);
        cts_n_i <= 1'b0;
        wait_idle(1'b0);
        chk("cts_level", STAT, 8'h01, 8'h00);
        wait_idle(1'b1);
        wr(CTRL, 8'h04);
        @(posedge clock_i);
        cts_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        `CHK("send_ok_free", 1'b1, tx_send_ok_o)
        chk("loop_empty", STAT, 8'h01, 8'h00);
        ulr_peer_inst.send_char(8'h77, 1'b0, 1'b1, 1'b0);
        chk("loop_full", STAT, 8'h81, 8'h81);
        chk("holding_loop", HOLD, 8'hFF, 8'h77);
        $display("test transmit done");
        wr(CTRL, 8'h00);
        ulr_peer_inst.lin_pulse('{1'b1, 1'b0, 1'b0, 1'b0, 8'h00});
        chk("std_no_echo", STAT, 8'h40, 8'h00);
        wr(CTRL, 8'h03);
        ulr_peer_inst.lin_pulse('{1'b1, 1'b0, 1'b0, 1'b0, 8'h00});
        chk("echo", STAT, 8'h40, 8'h40);
        chk("echo_clr", STAT, 8'h40, 8'h00);
        ulr_peer_inst.lin_pulse('{1'b1, 1'b0, 1'b0, 1'b0, 8'h00});
        rd(HOLD, d);
        chk("echo_hold_clr", STAT, 8'h40, 8'h00);
        ulr_peer_inst.lin_pulse('{1'b0, 1'b1, 1'b0, 1'b0, 8'h00});
        chk("autobaud", STAT, 8'h01, 8'h01);
        chk("autobaud_clr", STAT, 8'h01, 8'h00);
        ulr_peer_inst.lin_pulse('{1'b0, 1'b0, 1'b1, 1'b0, 8'h00});
        chk("ab_ovr", STAT, 8'h21, 8'h21);
        chk("ab_ovr_stat", STAT, 8'h21, 8'h20);
        rd(HOLD, d);
        chk("ab_ovr_clr", STAT, 8'h21, 8'h00);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock_i);
            lin_state_i <= st[i];
            ulr_peer_inst.lin_pulse('{1'b0, 1'b0, 1'b0, 1'b1, thr[i] - 8'h01});
            chk("brk_short", STAT, 8'h08, 8'h00);
            ulr_peer_inst.lin_pulse('{1'b0, 1'b0, 1'b0, 1'b1, thr[i]});
            chk("brk_lin", STAT, 8'h08, 8'h08);
            chk("brk_lin_clr", STAT, 8'h08, 8'h00);
        end
        @(posedge clock_i);
        lin_state_i <= LIN_OTHER;
        ulr_peer_inst.lin_pulse('{1'b0, 1'b0, 1'b0, 1'b1, 8'hFF});
        chk("brk_other", STAT, 8'h08, 8'h00);
        wr(CTRL, 8'h01);
        ulr_peer_inst.lin_pulse('{1'b0, 1'b1, 1'b0, 1'b0, 8'h00});
        chk("master_bit0", STAT, 8'h01, 8'h00);
        wr(CTRL, 8'h00);
        $display("test lin done");
        wr(ISTS, 8'hFF);
        wr(IMSK, 8'h01);
        `CHK("irq_idle", 1'b0, irq_o)
        ulr_peer_inst.send_char(8'h12, 1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge clock_i);
        `CHK("irq_set", 1'b1, irq_o)
        chk("irq_sts", ISTS, 8'hFF, 8'h01);
        rd(HOLD, d);
        wr(ISTS, 8'h01);
        repeat (2) @(posedge clock_i);
        `CHK("irq_clr", 1'b0, irq_o)
        wr(IMSK, 8'h00);
        ulr_peer_inst.send_char(8'h34, 1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge clock_i);
        `CHK("irq_masked", 1'b0, irq_o)
        chk("irq_sts_masked", ISTS, 8'hFF, 8'h01);
        $display("test interrupt done");
        @(posedge clock_i);
        ce_i <= 1'b0;
        wr(CTRL, 8'h0F);
        ulr_peer_inst.send_char(8'h99, 1'b0, 1'b1, 1'b0);
        @(posedge clock_i);
        ce_i <= 1'b1;
        chk("ce_ctrl", CTRL, 8'hFF, 8'h00);
        chk("ce_no_overrun", STAT, 8'hA0, 8'h80);
        chk("ce_hold", HOLD, 8'hFF, 8'h34);
        $display("test enable done");
        results();
    end
endmodule
